// ---- design/charger_switching_protection_ctrl.sv ----
// charger_switching_protection_ctrl: gate sequencing and fault handling for
// a synchronous buck charger, with option and charge current registers on
// a classic Wishbone slave.
// assumes all front-end comparator levels are synchronous to clk_i and
// that cycle_start pulses one clk_i cycle at each switching cycle start.
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module charger_switching_protection_ctrl
   import charger_pkg::*;
#(
   parameter logic [TMR_W-1:0] BLANK_CYC = TMR_W'(INPUT_OVERCURRENT_BLANK_CYC),
   parameter logic [TMR_W-1:0] HOLD_CYC = TMR_W'(INPUT_OVERCURRENT_HOLD_CYC),
   parameter logic [TMR_W-1:0] WINDOW_CYC = TMR_W'(INPUT_OVERCURRENT_WINDOW_CYC),
   parameter logic [TMR_W-1:0] OVP_CYC = TMR_W'(OVP_QUAL_CYC),
   parameter logic [TMR_W-1:0] BATLOW_CYC = TMR_W'(BATLOW_HOLD_CYC)
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // analog front-end
   input wire sense_in_t sense_i,
   output gate_out_t gate_o,
   output trim_out_t trim_o
);
   localparam logic [PH_W-1:0] DEAD_LAST = PH_W'(DEAD_CYC - 1);
   localparam logic [PH_W-1:0] REFRESH_LAST = PH_W'(REFRESH_CYC - 1);

   sense_in_t in_reg;
   logic [15:0] option_reg;
   logic [15:0] chg_cur_reg;
   gate_state_t state_reg;
   gate_state_t state_next;
   logic [PH_W-1:0] phase_reg;
   logic [PH_W-1:0] phase_next;
   logic sync_mode_reg;
   logic thermal_reg;
   logic input_overcurrent_hold_reg;
   logic input_overcurrent_latch_reg;
   logic window_reg;
   logic batlow_hold_reg;
   logic batlow_prev_reg;
   logic short_latch_reg;
   logic upper_short_prev_reg;
   logic lower_short_prev_reg;
   logic charge_en_reg;
   logic blank_done;
   logic hold_done;
   logic window_done;
   logic ovp_done;
   logic batlow_done;
   logic fail_reached;
   logic [EVT_W-1:0] fail_count;
   logic up_short_reached;
   logic lo_short_reached;
   logic trip_evt;
   logic latch_clear;
   logic charge_en_next;
   logic run_ok;
   logic bus_req;
   logic bus_wr;
   logic [31:0] rd_data;

   // every front-end level is registered once so all logic sees one edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_reg <= '0;
      end else begin
         in_reg <= sense_i;
      end
   end

   // wishbone: answer one cycle after the strobe, drop ack the cycle after
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr = bus_req && wb_we_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= (bus_req && !wb_we_i) ? rd_data : '0;
      end
   end

   // software writes option and charge current words through byte lanes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         option_reg <= OPTION_RST;
         chg_cur_reg <= CHG_CUR_RST;
      end else if (bus_wr) begin
         if (wb_adr_i == OPTION_OFS) begin
            if (wb_sel_i[0]) option_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) option_reg[15:8] <= wb_dat_i[15:8];
         end else if (wb_adr_i == CHG_CUR_OFS) begin
            if (wb_sel_i[0]) chg_cur_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) chg_cur_reg[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // read mux; unmapped addresses answer with zero
   always_comb begin
      rd_data = '0;
      case (wb_adr_i)
         OPTION_OFS: rd_data = {16'h0000, option_reg};
         CHG_CUR_OFS: rd_data = {16'h0000, chg_cur_reg};
         STATUS_OFS: rd_data = {20'h00000, fail_count, short_latch_reg, thermal_reg,
                                batlow_hold_reg, ovp_done, in_reg.battery_overvoltage,
                                input_overcurrent_latch_reg, input_overcurrent_hold_reg, sync_mode_reg, charge_en_reg};
         default: rd_data = '0;
      endcase
   end

   // input overcurrent must persist through the blanking interval
   hold_timer #(.W(TMR_W), .LIMIT(BLANK_CYC)) blank_tmr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(in_reg.input_overcurrent && (option_reg[OPT_INPUT_OVERCURRENT_LSB +: 2] != INPUT_OVERCURRENT_OFF)
             && !input_overcurrent_hold_reg && !input_overcurrent_latch_reg),
      .done_o(blank_done)
   );
   assign trip_evt = blank_done && !input_overcurrent_hold_reg;

   hold_timer #(.W(TMR_W), .LIMIT(HOLD_CYC)) hold_tmr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(input_overcurrent_hold_reg),
      .done_o(hold_done)
   );

   // counting window opens at a trip and closes when it elapses
   hold_timer #(.W(TMR_W), .LIMIT(WINDOW_CYC)) window_tmr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(window_reg && !window_done),
      .done_o(window_done)
   );

   assign latch_clear = in_reg.adapter_detect_low;

   // failure count is zeroed by window elapse or adapter removal
   event_counter #(.W(EVT_W), .TARGET(FAIL_LIMIT)) fail_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_i(window_done || latch_clear),
      .event_i(trip_evt),
      .count_o(fail_count),
      .reached_o(fail_reached)
   );

   // hold releases only once the timer ran out and the overload has gone
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         input_overcurrent_hold_reg <= 1'b0;
         window_reg <= 1'b0;
      end else begin
         if (trip_evt) begin
            input_overcurrent_hold_reg <= 1'b1;
         end else if (hold_done && !in_reg.input_overcurrent) begin
            input_overcurrent_hold_reg <= 1'b0;
         end
         window_reg <= trip_evt || (window_reg && !window_done);
      end
   end

   // latch-off after too many trips, cleared by adapter detect low only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         input_overcurrent_latch_reg <= 1'b0;
      end else if (latch_clear) begin
         input_overcurrent_latch_reg <= 1'b0;
      end else if (fail_reached) begin
         input_overcurrent_latch_reg <= 1'b1;
      end
   end

   // overvoltage longer than qualification time disables the charger
   hold_timer #(.W(TMR_W), .LIMIT(OVP_CYC)) ovp_tmr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(in_reg.battery_overvoltage),
      .done_o(ovp_done)
   );

   // battery low: a fixed pause from each rising entry into the fault
   hold_timer #(.W(TMR_W), .LIMIT(BATLOW_CYC)) batlow_tmr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(batlow_hold_reg),
      .done_o(batlow_done)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         batlow_prev_reg <= 1'b0;
         batlow_hold_reg <= 1'b0;
      end else begin
         batlow_prev_reg <= in_reg.battery_low_fault;
         if (in_reg.battery_low_fault && !batlow_prev_reg) begin
            batlow_hold_reg <= 1'b1;
         end else if (batlow_done) begin
            batlow_hold_reg <= 1'b0;
         end
      end
   end

   // thermal shutdown with hysteresis between the two die limits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         thermal_reg <= 1'b0;
      end else if (in_reg.die_above_upper) begin
         thermal_reg <= 1'b1;
      end else if (in_reg.die_below_lower) begin
         thermal_reg <= 1'b0;
      end
   end

   // short events are counted on comparator rising edges
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         upper_short_prev_reg <= 1'b0;
         lower_short_prev_reg <= 1'b0;
      end else begin
         upper_short_prev_reg <= in_reg.upper_short;
         lower_short_prev_reg <= in_reg.lower_short;
      end
   end

   event_counter #(.W(EVT_W), .TARGET(SHORT_LIMIT)) up_short_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_i(in_reg.supply_uvlo || latch_clear),
      .event_i(in_reg.upper_short && !upper_short_prev_reg),
      .count_o(),
      .reached_o(up_short_reached)
   );

   event_counter #(.W(EVT_W), .TARGET(SHORT_LIMIT)) lo_short_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_i(in_reg.supply_uvlo || latch_clear),
      .event_i(in_reg.lower_short && !lower_short_prev_reg),
      .count_o(),
      .reached_o(lo_short_reached)
   );

   // short latch holds until supply undervoltage or adapter removal
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         short_latch_reg <= 1'b0;
      end else if (in_reg.supply_uvlo || latch_clear) begin
         short_latch_reg <= 1'b0;
      end else if (up_short_reached || lo_short_reached) begin
         short_latch_reg <= 1'b1;
      end
   end

   // synchronous / non-synchronous selection with current hysteresis
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_mode_reg <= 1'b0;
      end else if (in_reg.avg_below_low || in_reg.battery_low_fault) begin
         sync_mode_reg <= 1'b0;
      end else if (in_reg.avg_above_high) begin
         sync_mode_reg <= 1'b1;
      end
   end

   // every stop condition but the immediate overvoltage (run_ok) gathered; a rise of the enable means soft-start
   assign charge_en_next = !option_reg[OPT_INHIBIT_BIT] && !input_overcurrent_hold_reg
                           && !input_overcurrent_latch_reg && !ovp_done && !batlow_hold_reg
                           && !thermal_reg && !short_latch_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         charge_en_reg <= 1'b0;
      end else begin
         charge_en_reg <= charge_en_next;
      end
   end

   // overvoltage stops any switch from turning on, immediately
   assign run_ok = charge_en_reg && !in_reg.battery_overvoltage;

   // gate sequencer; both switches are off in every state but three
   always_comb begin
      state_next = state_reg;
      phase_next = phase_reg;
      case (state_reg)
         S_IDLE: begin
            if (in_reg.cycle_start && run_ok) begin
               state_next = S_DEAD_HI;
               phase_next = DEAD_LAST;
            end
         end
         S_DEAD_HI: begin
            if (!run_ok) begin
               state_next = S_IDLE;
            end else if (phase_reg != '0) begin
               phase_next = phase_reg - PH_W'(1);
            end else if (in_reg.error_amp_above_ramp && !in_reg.charge_peak_overcurrent) begin
               state_next = S_UPPER;
            end else begin
               state_next = S_DEAD_LO;
               phase_next = DEAD_LAST;
            end
         end
         S_UPPER: begin
            // peak overcurrent ends the high side until the next cycle start
            if (!run_ok) begin
               state_next = S_IDLE;
            end else if (!in_reg.error_amp_above_ramp || in_reg.charge_peak_overcurrent
                         || in_reg.bootstrap_low) begin
               state_next = S_DEAD_LO;
               phase_next = DEAD_LAST;
            end
         end
         S_DEAD_LO: begin
            if (!run_ok) begin
               state_next = S_IDLE;
            end else if (in_reg.cycle_start) begin
               state_next = S_DEAD_HI;
               phase_next = DEAD_LAST;
            end else if (phase_reg != '0) begin
               phase_next = phase_reg - PH_W'(1);
            end else if (in_reg.bootstrap_low) begin
               state_next = S_REFRESH;
               phase_next = REFRESH_LAST;
            end else if (sync_mode_reg) begin
               state_next = S_LOWER;
            end else begin
               state_next = S_IDLE;
            end
         end
         S_LOWER: begin
            // low side ends at cycle end, on reverse current, or mode change
            if (in_reg.cycle_start && run_ok) begin
               state_next = S_DEAD_HI;
               phase_next = DEAD_LAST;
            end else if (!run_ok || in_reg.undercurrent_cmp || !sync_mode_reg) begin
               state_next = S_IDLE;
            end
         end
         S_REFRESH: begin
            if (in_reg.cycle_start && run_ok) begin
               state_next = S_DEAD_HI;
               phase_next = DEAD_LAST;
            end else if (!run_ok || phase_reg == '0) begin
               state_next = S_IDLE;
            end else begin
               phase_next = phase_reg - PH_W'(1);
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= S_IDLE;
         phase_reg <= '0;
      end else begin
         state_reg <= state_next;
         phase_reg <= phase_next;
      end
   end

   // gate outputs registered from the next state; path and limit outputs from the fault flags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_o <= '0;
      end else begin
         gate_o.upper_switch <= (state_next == S_UPPER);
         gate_o.lower_switch <= (state_next == S_LOWER) || (state_next == S_REFRESH);
         gate_o.adapter_path_switch <= !(input_overcurrent_hold_reg || input_overcurrent_latch_reg
                                         || short_latch_reg);
         gate_o.reverse_block_switch <= !(input_overcurrent_hold_reg || input_overcurrent_latch_reg || short_latch_reg);
         gate_o.battery_path_switch <= short_latch_reg;
         gate_o.discharge_sink <= in_reg.battery_overvoltage;
         gate_o.regulator_ilim_low <= thermal_reg;
         gate_o.charge_limit_low <= in_reg.battery_low_fault;
         gate_o.soft_start <= charge_en_next && !charge_en_reg;
      end
   end

   // trim selections; the peak level follows the programmed charge current
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trim_o <= '0;
      end else begin
         trim_o.input_overcurrent_level <= option_reg[OPT_INPUT_OVERCURRENT_LSB +: 2];
         trim_o.upper_short_level <= option_reg[OPT_SHORT_LSB +: 2];
         trim_o.freq_adjust_en <= option_reg[OPT_FADJ_EN_BIT];
         trim_o.freq_adjust_up <= option_reg[OPT_FADJ_UP_BIT];
         if (chg_cur_reg >= OCP_TH_HIGH) begin
            trim_o.ocp_level <= OCP_LVL_HIGH;
         end else if (chg_cur_reg >= OCP_TH_MID) begin
            trim_o.ocp_level <= OCP_LVL_MID;
         end else begin
            trim_o.ocp_level <= OCP_LVL_LOW;
         end
      end
   end
endmodule

// ---- common/charger_pkg.sv ----
// charger_pkg: shared constants, carrier structs and state type for the
// buck charger switching and protection controller.
// assumes a 100 MHz system clock; every time is converted to cycles here.
package charger_pkg;

   // clock and time bases
   localparam longint unsigned CLK_HZ = 100_000_000;
   localparam longint unsigned NS_PER_S = 1_000_000_000;
   localparam longint unsigned US_PER_S = 1_000_000;
   localparam longint unsigned MS_PER_S = 1_000;

   // times in their own units
   localparam longint unsigned DEAD_TIME_NS = 20;
   localparam longint unsigned REFRESH_NS = 200;
   localparam longint unsigned INPUT_OVERCURRENT_BLANK_US = 2500;
   localparam longint unsigned INPUT_OVERCURRENT_HOLD_MS = 1300;
   localparam longint unsigned INPUT_OVERCURRENT_WINDOW_S = 90;
   localparam longint unsigned OVP_QUAL_MS = 30;
   localparam longint unsigned BATLOW_HOLD_MS = 1;

   // derived cycle counts, rounded up as least times
   localparam longint unsigned DEAD_CYC = (DEAD_TIME_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S;
   localparam longint unsigned REFRESH_CYC = (REFRESH_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S;
   localparam longint unsigned INPUT_OVERCURRENT_BLANK_CYC = (INPUT_OVERCURRENT_BLANK_US * CLK_HZ + US_PER_S - 1) / US_PER_S;
   localparam longint unsigned INPUT_OVERCURRENT_HOLD_CYC = (INPUT_OVERCURRENT_HOLD_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
   localparam longint unsigned INPUT_OVERCURRENT_WINDOW_CYC = INPUT_OVERCURRENT_WINDOW_S * CLK_HZ;
   localparam longint unsigned OVP_QUAL_CYC = (OVP_QUAL_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
   localparam longint unsigned BATLOW_HOLD_CYC = (BATLOW_HOLD_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;

   // counter widths and event limits
   localparam int TMR_W = 34;
   localparam int PH_W = 6;
   localparam int EVT_W = 3;
   localparam logic [EVT_W-1:0] FAIL_LIMIT = 3'h7;
   localparam logic [EVT_W-1:0] SHORT_LIMIT = 3'h7;

   // register byte offsets
   localparam logic [7:0] OPTION_OFS = 8'h00;
   localparam logic [7:0] CHG_CUR_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;

   // option word fields and reset values
   localparam int OPT_INHIBIT_BIT = 0;
   localparam int OPT_INPUT_OVERCURRENT_LSB = 1;
   localparam int OPT_SHORT_LSB = 7;
   localparam int OPT_FADJ_EN_BIT = 9;
   localparam int OPT_FADJ_UP_BIT = 10;
   localparam logic [15:0] OPTION_RST = 16'h0004;
   localparam logic [15:0] CHG_CUR_RST = 16'h0000;
   localparam logic [1:0] INPUT_OVERCURRENT_OFF = 2'h0;

   // charge current word limits for the peak over-current level select
   localparam logic [15:0] OCP_TH_MID = 16'h0C00;
   localparam logic [15:0] OCP_TH_HIGH = 16'h1800;
   localparam logic [1:0] OCP_LVL_LOW = 2'h0;
   localparam logic [1:0] OCP_LVL_MID = 2'h1;
   localparam logic [1:0] OCP_LVL_HIGH = 2'h2;

   // comparator and sense front-end inputs
   typedef struct packed {
      logic cycle_start;
      logic error_amp_above_ramp;
      logic undercurrent_cmp;
      logic avg_below_low;
      logic avg_above_high;
      logic battery_low_fault;
      logic input_overcurrent;
      logic charge_peak_overcurrent;
      logic battery_overvoltage;
      logic die_above_upper;
      logic die_below_lower;
      logic bootstrap_low;
      logic upper_short;
      logic lower_short;
      logic supply_uvlo;
      logic adapter_detect_low;
   } sense_in_t;

   // gate drive and power path controls
   typedef struct packed {
      logic upper_switch;
      logic lower_switch;
      logic adapter_path_switch;
      logic reverse_block_switch;
      logic battery_path_switch;
      logic discharge_sink;
      logic regulator_ilim_low;
      logic charge_limit_low;
      logic soft_start;
   } gate_out_t;

   // analog trim selections handed to the front-end
   typedef struct packed {
      logic [1:0] input_overcurrent_level;
      logic [1:0] ocp_level;
      logic [1:0] upper_short_level;
      logic freq_adjust_en;
      logic freq_adjust_up;
   } trim_out_t;

   typedef enum logic [2:0] {
      S_IDLE, S_DEAD_HI, S_UPPER, S_DEAD_LO, S_LOWER, S_REFRESH
   } gate_state_t;

endpackage

// ---- design/hold_timer.sv ----
// hold_timer: counts clock cycles while run_i is high and flags when the
// programmed number of cycles has passed; dropping run_i restarts it.
// assumes run_i is already synchronous to clk_i.
`timescale 1ns/1ps
module hold_timer #(
   parameter int W = 34,
   parameter logic [W-1:0] LIMIT = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   output logic done_o
);
   logic [W-1:0] count_reg;

   // done rises LIMIT cycles after run_i rises and stays while run_i holds
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         count_reg <= '0;
         done_o <= 1'b0;
      end else if (!done_o) begin
         if (count_reg == LIMIT - W'(1)) begin
            done_o <= 1'b1;
         end else begin
            count_reg <= count_reg + W'(1);
         end
      end
   end
endmodule

// ---- design/event_counter.sv ----
// event_counter: saturating count of single-cycle events with a clear;
// flags when the target count is reached.
// assumes event_i is a one-cycle pulse synchronous to clk_i.
`timescale 1ns/1ps
module event_counter #(
   parameter int W = 3,
   parameter logic [W-1:0] TARGET = 7
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // events
   input wire logic clear_i,
   input wire logic event_i,
   output logic [W-1:0] count_o,
   output logic reached_o
);
   logic [W-1:0] count_next;

   // an event in the clearing cycle is kept as the first of a new count
   always_comb begin
      count_next = count_o;
      if (event_i) begin
         count_next = clear_i ? W'(1) : ((count_o == '1) ? count_o : count_o + W'(1));
      end else if (clear_i) begin
         count_next = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_o <= '0;
         reached_o <= 1'b0;
      end else begin
         count_o <= count_next;
         reached_o <= (count_next >= TARGET);
      end
   end
endmodule

// ---- dv/frontend_model.sv ----
// frontend_model: comparator front-end of the buck stage.
// assumes faults_i comes from the bench in step with clk_i.
`timescale 1ns/1ps
module frontend_model
   import charger_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bench faults in, comparator levels out
   input wire sense_in_t faults_i,
   output sense_in_t sense_o
);
   logic [5:0] phase_reg;
   // 48-clock ramp, long enough for both dead times and a lower phase
   always_ff @(posedge clk_i) begin
      if (rst_i || phase_reg == 6'h2F) begin
         phase_reg <= 6'h00;
      end else begin
         phase_reg <= phase_reg + 6'h01;
      end
   end
   // error above ramp early, inductor current dips to zero late
   always_comb begin
      sense_o = faults_i;
      sense_o.cycle_start = (phase_reg == 6'h00);
      sense_o.error_amp_above_ramp = (phase_reg < 6'h10);
      sense_o.undercurrent_cmp = faults_i.undercurrent_cmp | (phase_reg > 6'h2C);
   end
endmodule

// ---- dv/charger_monitor.sv ----
// charger_monitor: gate timing and bus answer checks.
// assumes it is bound to the controller top.
`timescale 1ns/1ps
module charger_monitor
   import charger_pkg::*;
(
   // watched ports
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire sense_in_t sense_i,
   input wire gate_out_t gate_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_no_overlap: assert property (!(gate_o.upper_switch && gate_o.lower_switch))
      else $error("both switches on");
   a_dead_gap: assert property ($fell(gate_o.upper_switch) |-> !gate_o.lower_switch [*2])
      else $error("dead time short");
   a_ovp_block: assert property (sense_i.battery_overvoltage [*2] |->
      ##1 !(gate_o.upper_switch || gate_o.lower_switch)) else $error("switch on in ovp");
   a_sink_on: assert property (sense_i.battery_overvoltage [*2] |-> ##1 gate_o.discharge_sink)
      else $error("sink off in ovp");
   a_ilim_low: assert property (sense_i.die_above_upper [*2] |->
      ##[1:3] gate_o.regulator_ilim_low) else $error("ilim not lowered");
   a_peak_cut: assert property (sense_i.charge_peak_overcurrent [*2] |->
      ##1 !gate_o.upper_switch) else $error("upper on in peak oc");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   a_short_path: assert property (gate_o.battery_path_switch |-> !gate_o.adapter_path_switch)
      else $error("both paths on");
endmodule

// ---- dv/testbench.sv ----
// testbench: wishbone tasks and fault sequences for the charger controller.
// assumes protection timers shortened through the top parameters.
`timescale 1ns/1ps
module testbench
   import charger_pkg::*;
;
   logic clk_i, rst_i, cyc, stb, we, ack;
   logic [3:0] sel;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, q;
   sense_in_t faults, sense;
   gate_out_t gate_o;
   trim_out_t trim_o;
   int failures, checks, up_cnt, lo_cnt, ss_cnt;
   logic [15:0] cur [3] = '{16'h0BFF, OCP_TH_MID, OCP_TH_HIGH};
   frontend_model i_fe (.clk_i(clk_i), .rst_i(rst_i), .faults_i(faults), .sense_o(sense));
   charger_switching_protection_ctrl #(.BLANK_CYC(34'h0A), .HOLD_CYC(34'h14),
      .WINDOW_CYC(34'h7D0), .OVP_CYC(34'h1E), .BATLOW_CYC(34'h0A)) i_dut (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .sense_i(sense), .gate_o(gate_o), .trim_o(trim_o));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // switch activity counters, read by the gate scenarios
   always @(posedge clk_i) begin
      up_cnt += int'(gate_o.upper_switch);
      lo_cnt += int'(gate_o.lower_switch);
      ss_cnt += int'(gate_o.soft_start);
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("failures %0d checks %0d", failures, checks);
      if (failures == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // one classic cycle; ack is waited for under a bound
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      {cyc, stb} <= 2'h0;
      @(posedge clk_i);
      if (n >= 20) begin
         failures++;
         summarize();
      end
   endtask
   // holds one fault level, then releases it
   task automatic hit(input sense_in_t f, input int on, input int off);
      faults <= f;
      tick(on);
      faults <= '0;
      tick(off);
   endtask
   initial begin
      {rst_i, cyc, stb, we, adr, wdat} = 44'h800_0000_0000;
      sel = 4'h3;
      faults = '0;
      tick(8);
      rst_i <= 1'b0;
      @(posedge clk_i);
      bus(1'b0, OPTION_OFS, 32'h0);
      cmp(q, 32'(OPTION_RST));
      bus(1'b0, 8'h0C, 32'h0);
      cmp(q, 32'h0);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, OPTION_OFS, 32'(i * 130 + i * 512));
         tick(2);
         cmp(trim_o, {2'(i), OCP_LVL_LOW, 2'(i), i[0], i[1]});
      end
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, CHG_CUR_OFS, 32'(cur[i]));
         tick(2);
         cmp(trim_o.ocp_level, 32'(i));
      end
      // the controller leaves reset non-synchronous; raise the average first
      faults <= '{avg_above_high: 1'b1, default: 1'b0};
      tick(200);
      cmp({up_cnt > 0, lo_cnt > 0}, 32'h3);
      faults <= '{avg_below_low: 1'b1, default: 1'b0};
      tick(60);
      lo_cnt = 0;
      tick(100);
      cmp(lo_cnt, 32'h0);
      faults <= '{avg_above_high: 1'b1, default: 1'b0};
      tick(100);
      cmp(lo_cnt > 0, 32'h1);
      faults <= '{charge_peak_overcurrent: 1'b1, default: 1'b0};
      tick(60);
      up_cnt = 0;
      tick(100);
      cmp(up_cnt, 32'h0);
      faults <= '{battery_overvoltage: 1'b1, default: 1'b0};
      tick(40);
      bus(1'b0, STATUS_OFS, 32'h0);
      cmp({q[5:4], gate_o.discharge_sink}, 32'h7);
      hit('0, 1, 5);
      cmp(gate_o.discharge_sink, 32'h0);
      hit('{die_above_upper: 1'b1, default: 1'b0}, 20, 20);
      cmp({gate_o.regulator_ilim_low, gate_o.upper_switch}, 32'h2);
      hit('{die_below_lower: 1'b1, default: 1'b0}, 5, 5);
      cmp(gate_o.regulator_ilim_low, 32'h0);
      // battery low: pause, reduced limit, lower off, then one soft restart
      faults <= '{battery_low_fault: 1'b1, default: 1'b0};
      ss_cnt = 0;
      tick(5);
      bus(1'b0, STATUS_OFS, 32'h0);
      cmp({q[6], q[0], gate_o.charge_limit_low}, 32'h5);
      lo_cnt = 0;
      tick(30);
      cmp({ss_cnt == 1, lo_cnt == 0}, 32'h3);
      faults <= '{battery_low_fault: 1'b1, bootstrap_low: 1'b1, default: 1'b0};
      tick(100);
      cmp(lo_cnt > 0, 32'h1);
      // six trips, let the window lapse, then seven more to latch
      for (int k = 0; k < 13; k++) begin
         hit('{input_overcurrent: 1'b1, default: 1'b0}, 20, 5);
         cmp({gate_o.adapter_path_switch, gate_o.reverse_block_switch}, 32'h0);
         tick(40);
         cmp(gate_o.adapter_path_switch, 32'(k != 12));
         if (k == 5) tick(2100);
      end
      hit('{adapter_detect_low: 1'b1, default: 1'b0}, 5, 5);
      cmp(gate_o.adapter_path_switch, 32'h1);
      for (int k = 0; k < 7; k++) begin
         cmp(gate_o.battery_path_switch, 32'h0);
         hit('{upper_short: 1'b1, default: 1'b0}, 3, 3);
      end
      cmp({gate_o.battery_path_switch, gate_o.adapter_path_switch}, 32'h2);
      hit('{supply_uvlo: 1'b1, default: 1'b0}, 5, 5);
      cmp(gate_o.battery_path_switch, 32'h0);
      summarize();
   end
endmodule
bind charger_switching_protection_ctrl charger_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sense_i(sense_i),
   .gate_o(gate_o));
